/* rtl/dpi_host_if.v */
/*
 Dual-port I2C host interface: two target ports with two addresses each
 and a maskable interrupt pin, plus a controller-only third port; the
 first port may be switched to controller. Assumes open-drain pads with
 pull-ups outside, pins asynchronous to clock, core logic on clock.
*/
// Summary of operation
// - targets run Standard and Fast open-drain I2C
// - first port target by default, controller optional
// - second port is target only
// - third port is controller only
// - per-port interrupt mask, independent of other
// - start is data fall with clock high
// - address byte MSB first, direction last
// - matching address acknowledged on ninth clock
// - data change with clock high is start/stop
// - stop is data rise with clock high
// - any byte count, one ack per byte
// - transmitter releases data before ack slot
// - target receiver acknowledges every byte
// - after NACK target releases data line
// - target stretches clock until core ready
// - each target answers two connector addresses
// - addresses set before targets respond
// - first interface address 0100 plus strap code
// - second interface connector-one address fixed 0111000
// - every address bit maskable per connector
// - strap codes 0xx connector one, 1xx two
// - second interface routes by connector address
`timescale 1ns/1ps
`include "dpi_host_if_defs.vh"

////////////////////////////////////////////////////////////////////////
module dpi_i2c_target (
	input wire clock,
	input wire arst_n,
	input wire enable,
	input wire [6:0] addr_one,
	input wire [6:0] addr_two,
	input wire scl_in,
	input wire sda_in,
	output reg scl_oe_n_q,
	output reg sda_oe_n_q,
	output reg [7:0] rx_data_q,
	output reg rx_valid_q,
	output reg conn_q,
	output reg rw_q,
	input wire rx_ready,
	input wire [7:0] tx_data,
	input wire tx_valid,
	output reg tx_take_q,
	output reg busy_q,
	input wire [3:0] evt,
	input wire [3:0] evt_clr,
	input wire [3:0] evt_mask,
	output reg [3:0] pend_q,
	output reg irq_oe_n_q
);
	localparam ST_IDLE = 3'h0;
	localparam ST_ADDR = 3'h1;
	localparam ST_AACK = 3'h2;
	localparam ST_RX = 3'h3;
	localparam ST_RACK = 3'h4;
	localparam ST_TX = 3'h5;
	localparam ST_TACK = 3'h6;
	localparam ST_IGN = 3'h7;
	reg [2:0] scl_s;
	reg [2:0] sda_s;
	reg [2:0] st_q;
	reg [3:0] cnt_q;
	reg [7:0] sh_q;
	reg hold_q;
	reg ack_q;
	reg rel_q;
	wire scl_rise = scl_s[1] & ~scl_s[2];
	wire scl_fall = ~scl_s[1] & scl_s[2];
	wire start_c = scl_s[1] & scl_s[2] & sda_s[2] & ~sda_s[1];
	wire stop_c = scl_s[1] & scl_s[2] & ~sda_s[2] & sda_s[1];
	wire go = scl_fall | hold_q;
	wire hit_one = (sh_q[7:1] == addr_one);
	wire hit_two = (sh_q[7:1] == addr_two);
	wire want_tx = (st_q == ST_AACK) ? rw_q : ack_q;

	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			scl_s <= 3'h7;
			sda_s <= 3'h7;
			st_q <= ST_IDLE;
			cnt_q <= 4'h0;
			sh_q <= 8'h00;
			hold_q <= 1'b0;
			ack_q <= 1'b0;
			rel_q <= 1'b0;
			scl_oe_n_q <= 1'b1;
			sda_oe_n_q <= 1'b1;
			rx_data_q <= 8'h00;
			rx_valid_q <= 1'b0;
			conn_q <= 1'b0;
			rw_q <= 1'b0;
			tx_take_q <= 1'b0;
			busy_q <= 1'b0;
			pend_q <= 4'h0;
			irq_oe_n_q <= 1'b1;
		end else begin
			scl_s <= {scl_s[1:0], scl_in};
			sda_s <= {sda_s[1:0], sda_in};
			rx_valid_q <= 1'b0;
			tx_take_q <= 1'b0;
			// Clock let go one cycle after data settles
			rel_q <= 1'b0;
			if (rel_q)
				scl_oe_n_q <= 1'b1;
			busy_q <= (st_q != ST_IDLE);
			pend_q <= (pend_q & ~evt_clr) | evt;
			irq_oe_n_q <= ~|(pend_q & evt_mask);
			if (!enable || stop_c) begin
				st_q <= ST_IDLE;
				hold_q <= 1'b0;
				scl_oe_n_q <= 1'b1;
				sda_oe_n_q <= 1'b1;
			end else if (start_c) begin
				st_q <= ST_ADDR;
				cnt_q <= 4'h0;
				sda_oe_n_q <= 1'b1;
			end else begin
				if (scl_rise) begin
					cnt_q <= cnt_q + 4'h1;
					if (st_q == ST_ADDR || st_q == ST_RX)
						sh_q <= {sh_q[6:0], sda_s[1]};
					if (st_q == ST_TACK)
						ack_q <= ~sda_s[1];
				end
				if (go) begin
					case (st_q)
					ST_ADDR: if (cnt_q == `DPI_BYTE_BITS) begin
						if (hit_one || hit_two) begin
							sda_oe_n_q <= 1'b0;
							conn_q <= ~hit_one;
							rw_q <= sh_q[0];
							st_q <= ST_AACK;
						end else begin
							st_q <= ST_IGN;
						end
					end
					ST_AACK, ST_TACK: if (want_tx) begin
						if (tx_valid) begin
							sh_q <= {tx_data[6:0], 1'b0};
							sda_oe_n_q <= tx_data[7];
							tx_take_q <= 1'b1;
							cnt_q <= 4'h0;
							hold_q <= 1'b0;
							rel_q <= hold_q;
							st_q <= ST_TX;
						end else begin
							hold_q <= 1'b1;
							scl_oe_n_q <= 1'b0;
							sda_oe_n_q <= 1'b1;
						end
					end else if (st_q == ST_AACK) begin
						sda_oe_n_q <= 1'b1;
						cnt_q <= 4'h0;
						st_q <= ST_RX;
					end else begin
						sda_oe_n_q <= 1'b1;
						st_q <= ST_IGN;
					end
					ST_RX: if (cnt_q == `DPI_BYTE_BITS) begin
						if (rx_ready) begin
							hold_q <= 1'b0;
							rel_q <= hold_q;
							sda_oe_n_q <= 1'b0;
							rx_data_q <= sh_q;
							rx_valid_q <= 1'b1;
							st_q <= ST_RACK;
						end else begin
							hold_q <= 1'b1;
							scl_oe_n_q <= 1'b0;
						end
					end
					ST_RACK: begin
						sda_oe_n_q <= 1'b1;
						cnt_q <= 4'h0;
						st_q <= ST_RX;
					end
					ST_TX: if (cnt_q == `DPI_BYTE_BITS) begin
						sda_oe_n_q <= 1'b1;
						st_q <= ST_TACK;
					end else begin
						sda_oe_n_q <= sh_q[7];
						sh_q <= {sh_q[6:0], 1'b0};
					end
					default: begin
					end
					endcase
				end
			end
		end
	end
endmodule

////////////////////////////////////////////////////////////////////////
module dpi_i2c_ctrl (
	input wire clock,
	input wire arst_n,
	input wire scl_in,
	input wire sda_in,
	output reg scl_oe_n_q,
	output reg sda_oe_n_q,
	input wire cmd_valid,
	input wire [6:0] cmd_addr,
	input wire cmd_rw,
	input wire [7:0] cmd_data,
	output reg busy_q,
	output reg done_q,
	output reg nack_q,
	output reg [7:0] rd_data_q
);
	localparam C_IDLE = 2'h0;
	localparam C_START = 2'h1;
	localparam C_BITS = 2'h2;
	localparam C_STOP = 2'h3;
	reg [1:0] scl_s;
	reg [1:0] sda_s;
	reg [1:0] cs_q;
	reg [1:0] ph_q;
	reg [6:0] q_q;
	reg [4:0] bit_q;
	reg [17:0] vec_q;
	reg [17:0] rxv_q;
	reg rw_q;
	wire tick = (q_q == `DPI_QTR_CYC - 1);
	wire run = (ph_q != 2'h1) | scl_s[1];

	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			scl_s <= 2'h3;
			sda_s <= 2'h3;
			cs_q <= C_IDLE;
			ph_q <= 2'h0;
			q_q <= 7'h00;
			bit_q <= 5'h00;
			vec_q <= 18'h3FFFF;
			rxv_q <= 18'h00000;
			rw_q <= 1'b0;
			scl_oe_n_q <= 1'b1;
			sda_oe_n_q <= 1'b1;
			busy_q <= 1'b0;
			done_q <= 1'b0;
			nack_q <= 1'b0;
			rd_data_q <= 8'h00;
		end else begin
			scl_s <= {scl_s[0], scl_in};
			sda_s <= {sda_s[0], sda_in};
			done_q <= 1'b0;
			if (cs_q == C_IDLE) begin
				q_q <= 7'h00;
				ph_q <= 2'h0;
				if (cmd_valid) begin
					cs_q <= C_START;
					busy_q <= 1'b1;
					rw_q <= cmd_rw;
					sda_oe_n_q <= 1'b0;
					vec_q <= {cmd_addr, cmd_rw, 1'b1, cmd_rw ? 8'hFF : cmd_data, 1'b1};
				end
			end else if (run) begin
				q_q <= tick ? 7'h00 : q_q + 7'h01;
				if (tick) begin
					ph_q <= ph_q + 2'h1;
					case (cs_q)
					C_START: if (ph_q == 2'h1) begin
						scl_oe_n_q <= 1'b0;
						sda_oe_n_q <= vec_q[17];
						bit_q <= 5'h00;
						ph_q <= 2'h0;
						cs_q <= C_BITS;
					end
					C_BITS: case (ph_q)
					2'h0: scl_oe_n_q <= 1'b1;
					2'h1: rxv_q <= {rxv_q[16:0], sda_s[1]};
					2'h2: scl_oe_n_q <= 1'b0;
					default: if (bit_q == `DPI_LAST_BIT) begin
						cs_q <= C_STOP;
						sda_oe_n_q <= 1'b0;
					end else begin
						bit_q <= bit_q + 5'h01;
						vec_q <= {vec_q[16:0], 1'b1};
						sda_oe_n_q <= vec_q[16];
					end
					endcase
					default: case (ph_q)
					2'h0: scl_oe_n_q <= 1'b1;
					2'h1: sda_oe_n_q <= 1'b1;
					default: begin
						cs_q <= C_IDLE;
						busy_q <= 1'b0;
						done_q <= 1'b1;
						nack_q <= rxv_q[9] | (~rw_q & rxv_q[0]);
						rd_data_q <= rxv_q[8:1];
					end
					endcase
					endcase
				end
			end
		end
	end
endmodule

////////////////////////////////////////////////////////////////////////
module dpi_host_if (
	input wire clock,
	input wire arst_n,
	input wire boot_done,
	input wire p1_ctrl_mode,
	input wire [1:0] address_strap_analog_in,
	input wire [6:0] p1_ovr_one,
	input wire [6:0] p1_ovr_two,
	input wire [6:0] p1_mask_one,
	input wire [6:0] p1_mask_two,
	input wire [6:0] p2_ovr_one,
	input wire [6:0] p2_ovr_two,
	input wire [6:0] p2_mask_one,
	input wire [6:0] p2_mask_two,
	input wire p1_scl_in,
	output wire p1_scl_out,
	output reg p1_scl_oe_n_q,
	input wire p1_sda_in,
	output wire p1_sda_out,
	output reg p1_sda_oe_n_q,
	output wire first_port_irq_out,
	output wire first_port_irq_out_oe_n,
	input wire p2_scl_in,
	output wire p2_scl_out,
	output wire p2_scl_oe_n,
	input wire p2_sda_in,
	output wire p2_sda_out,
	output wire p2_sda_oe_n,
	output wire second_port_irq_out,
	output wire second_port_irq_out_oe_n,
	input wire p3_scl_in,
	output wire p3_scl_out,
	output wire p3_scl_oe_n,
	input wire p3_sda_in,
	output wire p3_sda_out,
	output wire p3_sda_oe_n,
	input wire third_port_irq_in,
	output reg p3_irq_seen_q,
	output wire [7:0] p1_rx_data,
	output wire p1_rx_valid,
	output wire p1_conn,
	output wire p1_rw,
	input wire p1_rx_ready,
	input wire [7:0] p1_tx_data,
	input wire p1_tx_valid,
	output wire p1_tx_take,
	output wire p1_busy,
	input wire [3:0] p1_evt,
	input wire [3:0] p1_evt_clr,
	input wire [3:0] p1_evt_mask,
	output wire [3:0] p1_pend,
	output wire [7:0] p2_rx_data,
	output wire p2_rx_valid,
	output wire p2_conn,
	output wire p2_rw,
	input wire p2_rx_ready,
	input wire [7:0] p2_tx_data,
	input wire p2_tx_valid,
	output wire p2_tx_take,
	output wire p2_busy,
	input wire [3:0] p2_evt,
	input wire [3:0] p2_evt_clr,
	input wire [3:0] p2_evt_mask,
	output wire [3:0] p2_pend,
	input wire c1_cmd_valid,
	input wire [6:0] c1_cmd_addr,
	input wire c1_cmd_rw,
	input wire [7:0] c1_cmd_data,
	output wire c1_busy,
	output wire c1_done,
	output wire c1_nack,
	output wire [7:0] c1_rd_data,
	input wire c3_cmd_valid,
	input wire [6:0] c3_cmd_addr,
	input wire c3_cmd_rw,
	input wire [7:0] c3_cmd_data,
	output wire c3_busy,
	output wire c3_done,
	output wire c3_nack,
	output wire [7:0] c3_rd_data
);
	reg [1:0] strap_s1_q;
	reg [1:0] strap_s2_q;
	reg [1:0] irq3_s_q;
	reg [2:0] strap_addr_code_conn_one;
	reg [2:0] strap_addr_code_conn_two;
	reg armed_q;
	reg p1_mode_q;
	wire t1_scl_oe_n;
	wire t1_sda_oe_n;
	wire k1_scl_oe_n;
	wire k1_sda_oe_n;

	function [6:0] dpi_addr;
		input [6:0] dflt;
		input [6:0] ovr;
		input [6:0] msk;
		dpi_addr = (dflt & ~msk) | (ovr & msk);
	endfunction

	assign p1_scl_out = 1'b0;
	assign p1_sda_out = 1'b0;
	assign p2_scl_out = 1'b0;
	assign p2_sda_out = 1'b0;
	assign p3_scl_out = 1'b0;
	assign p3_sda_out = 1'b0;
	assign first_port_irq_out = 1'b0;
	assign second_port_irq_out = 1'b0;

	////////////////////////////////////////////////////////////////////
	// Boot capture of strap code and port one role
	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			strap_s1_q <= 2'h0;
			strap_s2_q <= 2'h0;
			irq3_s_q <= 2'h3;
			p3_irq_seen_q <= 1'b0;
			strap_addr_code_conn_one <= 3'h0;
			strap_addr_code_conn_two <= 3'h4;
			armed_q <= 1'b0;
			p1_mode_q <= 1'b0;
			p1_scl_oe_n_q <= 1'b1;
			p1_sda_oe_n_q <= 1'b1;
		end else begin
			strap_s1_q <= address_strap_analog_in;
			strap_s2_q <= strap_s1_q;
			irq3_s_q <= {irq3_s_q[0], third_port_irq_in};
			p3_irq_seen_q <= ~irq3_s_q[1];
			if (!boot_done) begin
				armed_q <= 1'b0;
			end else if (!armed_q) begin
				strap_addr_code_conn_one <= {`DPI_CONN_ONE_PFX, strap_s2_q};
				strap_addr_code_conn_two <= {`DPI_CONN_TWO_PFX, strap_s2_q};
				p1_mode_q <= p1_ctrl_mode;
				armed_q <= 1'b1;
			end
			p1_scl_oe_n_q <= p1_mode_q ? k1_scl_oe_n : t1_scl_oe_n;
			p1_sda_oe_n_q <= p1_mode_q ? k1_sda_oe_n : t1_sda_oe_n;
		end
	end

	////////////////////////////////////////////////////////////////////
	// First interface, target role
	dpi_i2c_target u_t1 (
		.clock(clock),
		.arst_n(arst_n),
		.enable(armed_q & ~p1_mode_q),
		.addr_one(dpi_addr({`DPI_P1_ADDR_HI, strap_addr_code_conn_one},
			p1_ovr_one, p1_mask_one)),
		.addr_two(dpi_addr({`DPI_P1_ADDR_HI, strap_addr_code_conn_two},
			p1_ovr_two, p1_mask_two)),
		.scl_in(p1_scl_in),
		.sda_in(p1_sda_in),
		.scl_oe_n_q(t1_scl_oe_n),
		.sda_oe_n_q(t1_sda_oe_n),
		.rx_data_q(p1_rx_data),
		.rx_valid_q(p1_rx_valid),
		.conn_q(p1_conn),
		.rw_q(p1_rw),
		.rx_ready(p1_rx_ready),
		.tx_data(p1_tx_data),
		.tx_valid(p1_tx_valid),
		.tx_take_q(p1_tx_take),
		.busy_q(p1_busy),
		.evt(p1_evt),
		.evt_clr(p1_evt_clr),
		.evt_mask(p1_evt_mask),
		.pend_q(p1_pend),
		.irq_oe_n_q(first_port_irq_out_oe_n)
	);

	// First interface, controller role
	dpi_i2c_ctrl u_c1 (
		.clock(clock),
		.arst_n(arst_n),
		.scl_in(p1_scl_in),
		.sda_in(p1_sda_in),
		.scl_oe_n_q(k1_scl_oe_n),
		.sda_oe_n_q(k1_sda_oe_n),
		.cmd_valid(c1_cmd_valid & p1_mode_q & armed_q),
		.cmd_addr(c1_cmd_addr),
		.cmd_rw(c1_cmd_rw),
		.cmd_data(c1_cmd_data),
		.busy_q(c1_busy),
		.done_q(c1_done),
		.nack_q(c1_nack),
		.rd_data_q(c1_rd_data)
	);

	////////////////////////////////////////////////////////////////////
	// Second interface, target only
	dpi_i2c_target u_t2 (
		.clock(clock),
		.arst_n(arst_n),
		.enable(armed_q),
		.addr_one(dpi_addr(`DPI_P2_ADDR_ONE, p2_ovr_one, p2_mask_one)),
		.addr_two(dpi_addr(`DPI_P2_ADDR_TWO, p2_ovr_two, p2_mask_two)),
		.scl_in(p2_scl_in),
		.sda_in(p2_sda_in),
		.scl_oe_n_q(p2_scl_oe_n),
		.sda_oe_n_q(p2_sda_oe_n),
		.rx_data_q(p2_rx_data),
		.rx_valid_q(p2_rx_valid),
		.conn_q(p2_conn),
		.rw_q(p2_rw),
		.rx_ready(p2_rx_ready),
		.tx_data(p2_tx_data),
		.tx_valid(p2_tx_valid),
		.tx_take_q(p2_tx_take),
		.busy_q(p2_busy),
		.evt(p2_evt),
		.evt_clr(p2_evt_clr),
		.evt_mask(p2_evt_mask),
		.pend_q(p2_pend),
		.irq_oe_n_q(second_port_irq_out_oe_n)
	);

	////////////////////////////////////////////////////////////////////
	// Third interface, controller only
	dpi_i2c_ctrl u_c3 (
		.clock(clock),
		.arst_n(arst_n),
		.scl_in(p3_scl_in),
		.sda_in(p3_sda_in),
		.scl_oe_n_q(p3_scl_oe_n),
		.sda_oe_n_q(p3_sda_oe_n),
		.cmd_valid(c3_cmd_valid),
		.cmd_addr(c3_cmd_addr),
		.cmd_rw(c3_cmd_rw),
		.cmd_data(c3_cmd_data),
		.busy_q(c3_busy),
		.done_q(c3_done),
		.nack_q(c3_nack),
		.rd_data_q(c3_rd_data)
	);
endmodule

/* rtl/dpi_host_if_defs.vh */
/*
 Constants of the dual-port I2C host interface: address fields, strap
 codes and timing counts. Assumes the includer uses them as plain text.
*/
`ifndef DPI_HOST_IF_DEFS_VH
`define DPI_HOST_IF_DEFS_VH

// Core clock rate
`define DPI_CLK_MHZ 20
// First interface address, bits 7..4 of the byte
`define DPI_P1_ADDR_HI 4'h4
// Strap code prefixes per connector
`define DPI_CONN_ONE_PFX 1'b0
`define DPI_CONN_TWO_PFX 1'b1
// Second interface fixed addresses, bits 7..1 of the byte
`define DPI_P2_ADDR_ONE 7'h38
`define DPI_P2_ADDR_TWO 7'h3F
// Bit count at the end of a byte
`define DPI_BYTE_BITS 4'h8
// Controller bit index of the last frame bit
`define DPI_LAST_BIT 5'h11
// Controller quarter bit time, least time, rounded up
`define DPI_QTR_NS 2500
`define DPI_QTR_CYC ((`DPI_QTR_NS * `DPI_CLK_MHZ + 999) / 1000)

`endif

/* rtl/dpi_host_if_x.v */
`timescale 1ns/1ps

/* verif/dpi_host_if_asserts.sv */
/*
 Checker on the ports of the host interface top.
 Assumes a single clock domain and the bench's pull-up wire resolution.
*/
`timescale 1ns/1ps
module dpi_host_if_chk (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic boot_done,
	input wire logic p1_sda_oe_n_q,
	input wire logic p2_scl_in,
	input wire logic p2_scl_oe_n,
	input wire logic p2_sda_oe_n,
	input wire logic p2_scl_out,
	input wire logic p2_sda_out,
	input wire logic p2_busy,
	input wire logic p2_rx_valid,
	input wire logic [3:0] p2_pend,
	input wire logic [3:0] p2_evt_clr,
	input wire logic [3:0] p2_evt_mask,
	input wire logic second_port_irq_out_oe_n,
	input wire logic p3_scl_oe_n,
	input wire logic p3_sda_oe_n,
	input wire logic c3_cmd_valid,
	input wire logic c3_busy,
	input wire logic c3_done
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!arst_n);

	////////////////////////////////////////////////////////////////////////
	a_pre_boot_quiet: assert property (!boot_done |-> p2_sda_oe_n && p2_scl_oe_n && p1_sda_oe_n_q)
		else $error("target drove a line before boot");
	a_target_no_clock: assert property ((!p2_busy) [*3] |-> p2_scl_oe_n)
		else $error("port two drove clock while idle");
	a_sda_clock_low: assert property ($changed(p2_sda_oe_n) |-> !p2_scl_in)
		else $error("port two moved data while clock high");
	a_irq_pending_on: assert property ((|(p2_pend & p2_evt_mask)) [*2] |-> !second_port_irq_out_oe_n)
		else $error("interrupt not driven while pending");
	a_irq_clear_off: assert property (((p2_pend & p2_evt_mask) == 4'h0) [*2] |-> second_port_irq_out_oe_n)
		else $error("interrupt driven with nothing pending");
	a_pend_only_clr: assert property (|($past(p2_pend) & ~p2_pend) |-> |($past(p2_evt_clr) | $past(p2_evt_clr, 2)))
		else $error("pending bit dropped without clear");
	a_cmd_taken: assert property (c3_cmd_valid && !c3_busy && !c3_done |-> ##[1:2] c3_busy)
		else $error("idle controller ignored command");
	a_ctrl_idle_free: assert property ((!c3_busy) [*3] |-> p3_scl_oe_n && p3_sda_oe_n)
		else $error("controller drove bus while idle");
	a_pins_open_drain: assert property (!p2_scl_out && !p2_sda_out)
		else $error("open-drain output level not low");

	c_rx_byte: cover property (p2_rx_valid);
	c_stretch: cover property ($fell(p2_scl_oe_n));
	c_ctrl_done: cover property (c3_done);
endmodule

bind dpi_host_if dpi_host_if_chk chk_u (.*);

/* verif/dpi_i2c_model.sv */
/*
 Behavioural bus controller that stands on the far side of target port two.
 Assumes the bench resolves the open-drain wires with pull-ups and feeds them back.
*/
`timescale 1ns/1ps
module dpi_i2c_model (
	input wire logic clock,
	input wire logic scl,
	input wire logic sda,
	output logic scl_q,
	output logic sda_q
);
	integer stretch_n;

	initial begin
		scl_q = 1'h1;
		sda_q = 1'h1;
		stretch_n = 0;
	end

	////////////////////////////////////////////////////////////////////////
	task q(input integer n);
		repeat (n) @(posedge clock);
	endtask

	// One bit, 400 ns: 5 cycles low, 3 high
	task bit_io(input logic b, output logic r);
		integer w;
		begin
			w = 0;
			q(2);
			sda_q <= b;
			q(3);
			scl_q <= 1'h1;
			q(1);
			while (scl !== 1'h1 && w < 2000) begin
				w = w + 1;
				q(1);
			end
			stretch_n = stretch_n + w;
			q(2);
			r = sda;
			scl_q <= 1'h0;
		end
	endtask

	task start;
		sda_q <= 1'h1;
		scl_q <= 1'h1;
		q(4);
		sda_q <= 1'h0;
		q(4);
		scl_q <= 1'h0;
	endtask

	task stop;
		q(2);
		sda_q <= 1'h0;
		q(3);
		scl_q <= 1'h1;
		q(4);
		sda_q <= 1'h1;
		q(8);
	endtask

	task write_byte(input logic [7:0] b, output logic ack);
		integer i;
		logic r;
		begin
			for (i = 7; i >= 0; i = i - 1) begin
				bit_io(b[i], r);
			end
			bit_io(1'h1, r);
			ack = !r;
		end
	endtask

	task read_byte(input logic last, output logic [7:0] d);
		integer i;
		logic r;
		begin
			for (i = 7; i >= 0; i = i - 1) begin
				bit_io(1'h1, r);
				d[i] = r;
			end
			bit_io(last, r);
		end
	endtask
endmodule

/* verif/test_dual_port_i2c_host_interface.sv */
/*
 Self-checking bench for the host interface: a model controller on port two,
 port three looped onto port one. Assumes pull-ups on every open-drain wire.
*/
`timescale 1ns/1ps
module test_dual_port_i2c_host_interface;
	logic clock, arst_n, boot_done, p1_ctrl_mode, p1_rx_ready, p1_tx_valid;
	logic p2_rx_ready, p2_tx_valid, third_port_irq_in, c1_cmd_valid, c1_cmd_rw;
	logic c3_cmd_valid, c3_cmd_rw;
	logic [1:0] address_strap_analog_in;
	logic [6:0] p1_ovr_one, p1_ovr_two, p1_mask_one, p1_mask_two, c1_cmd_addr, c3_cmd_addr;
	logic [6:0] p2_ovr_one, p2_ovr_two, p2_mask_one, p2_mask_two;
	logic [7:0] p1_tx_data, p2_tx_data, c1_cmd_data, c3_cmd_data, d, r;
	logic [3:0] p1_evt, p1_evt_clr, p1_evt_mask, p2_evt, p2_evt_clr, p2_evt_mask;
	wire p1_scl_out, p1_sda_out, p1_scl_oe_n_q, p1_sda_oe_n_q, first_port_irq_out;
	wire first_port_irq_out_oe_n, p2_scl_out, p2_scl_oe_n, p2_sda_out, p2_sda_oe_n;
	wire second_port_irq_out, second_port_irq_out_oe_n, p3_scl_out, p3_scl_oe_n;
	wire p3_sda_out, p3_sda_oe_n, p3_irq_seen_q, m_scl, m_sda;
	wire [7:0] p1_rx_data, p2_rx_data, c1_rd_data, c3_rd_data;
	wire p1_rx_valid, p1_conn, p1_rw, p1_tx_take, p1_busy;
	wire p2_rx_valid, p2_conn, p2_rw, p2_tx_take, p2_busy;
	wire [3:0] p1_pend, p2_pend;
	wire c1_busy, c1_done, c1_nack, c3_busy, c3_done, c3_nack;
	wire p1_scl_in = p3_scl_oe_n & p1_scl_oe_n_q;
	wire p1_sda_in = p3_sda_oe_n & p1_sda_oe_n_q;
	wire p3_scl_in = p1_scl_in;
	wire p3_sda_in = p1_sda_in;
	wire p2_scl_in = m_scl & p2_scl_oe_n;
	wire p2_sda_in = m_sda & p2_sda_oe_n;
	integer failures, n_compared, cycles, seed, base, k;
	logic ack;
	logic [8:0] exp_q[$];

	dpi_host_if dut_u (.*);
	dpi_i2c_model model_u (.clock(clock), .scl(p2_scl_in), .sda(p2_sda_in), .scl_q(m_scl),
		.sda_q(m_sda));

	initial begin
		clock = 1'h0;
		forever #25 clock = ~clock;
	end

	////////////////////////////////////////////////////////////////////////
	task final_report;
		$display("comparisons %0d mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task check1(input logic got, input logic exp);
		n_compared = n_compared + 1;
		if (got !== exp) begin
			failures = failures + 1;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task check8(input logic [7:0] got, input logic [7:0] exp);
		n_compared = n_compared + 1;
		if (got !== exp) begin
			failures = failures + 1;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task tick(input integer n);
		repeat (n) @(posedge clock);
	endtask

	// Write nb random bytes to port two
	task p2_xfer(input logic [6:0] a, input integer nb, input logic exp_ack, input logic c);
		integer i;
		begin
			model_u.start;
			model_u.write_byte({a, 1'h0}, ack);
			check1(ack, exp_ack);
			for (i = 0; i < nb && ack; i = i + 1) begin
				d = $urandom;
				exp_q.push_back({c, d});
				model_u.write_byte(d, ack);
				check1(ack, 1'h1);
			end
			model_u.stop;
		end
	endtask

	task c3_cmd(input logic [6:0] a, input logic rw, input logic [7:0] v);
		integer w;
		begin
			c3_cmd_addr <= a;
			c3_cmd_rw <= rw;
			c3_cmd_data <= v;
			c3_cmd_valid <= 1'h1;
			w = 0;
			tick(1);
			while (c3_busy !== 1'h1 && w < 10) begin
				w = w + 1;
				tick(1);
			end
			c3_cmd_valid <= 1'h0;
			while (c3_done !== 1'h1 && w < 9000) begin
				w = w + 1;
				tick(1);
			end
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	// Received bytes against the expected queue
	always @(posedge clock) begin
		cycles = cycles + 1;
		if (cycles == 60000) begin
			failures = failures + 1;
			final_report;
		end
		if (p1_rx_valid === 1'h1 || p2_rx_valid === 1'h1) begin
			check8(p2_rx_valid ? p2_rx_data : p1_rx_data, exp_q[0][7:0]);
			check1(p2_rx_valid ? p2_conn : p1_conn, exp_q[0][8]);
			exp_q.pop_front();
		end
		if (p1_tx_take === 1'h1)
			p1_tx_valid <= 1'h0;
		if (p2_tx_take === 1'h1)
			p2_tx_valid <= 1'h0;
	end

	initial begin
		{failures, n_compared, cycles} = 0;
		{arst_n, boot_done, p1_ctrl_mode, p1_tx_valid, p2_tx_valid} = 5'h0;
		{c1_cmd_valid, c1_cmd_rw, c3_cmd_valid, c3_cmd_rw} = 4'h0;
		{p1_rx_ready, p2_rx_ready, third_port_irq_in} = 3'h7;
		address_strap_analog_in = 2'h2;
		{p1_ovr_one, p1_ovr_two, p1_mask_one, p1_mask_two, c1_cmd_addr, c3_cmd_addr} = 42'h0;
		{p2_ovr_one, p2_ovr_two, p2_mask_one, p2_mask_two} = 28'h0;
		{p1_tx_data, p2_tx_data, c1_cmd_data, c3_cmd_data} = 32'h0;
		{p1_evt, p1_evt_clr, p1_evt_mask, p2_evt, p2_evt_clr, p2_evt_mask} = 24'h0;
		seed = $urandom(52);
		tick(5);
		arst_n <= 1'h1;
		tick(2);
		p2_xfer(7'h38, 0, 1'h0, 1'h0);
		$display("pre-boot test done");
		boot_done <= 1'h1;
		tick(3);
		p2_xfer(7'h38, 2, 1'h1, 1'h0);
		p2_xfer(7'h3F, 1, 1'h1, 1'h1);
		p2_xfer(7'h55, 0, 1'h0, 1'h0);
		$display("address test done");
		d = $urandom;
		p2_tx_data <= d;
		p2_tx_valid <= 1'h1;
		model_u.start;
		model_u.write_byte({7'h38, 1'h1}, ack);
		check1(ack, 1'h1);
		model_u.read_byte(1'h1, r);
		model_u.stop;
		check8(r, d);
		check1(p2_rw, 1'h1);
		$display("read test done");
		p2_rx_ready <= 1'h0;
		fork
			begin
				tick(300);
				p2_rx_ready <= 1'h1;
			end
		join_none
		base = model_u.stretch_n;
		p2_xfer(7'h38, 1, 1'h1, 1'h0);
		check1(model_u.stretch_n - base > 50, 1'h1);
		$display("stretch test done");
		p2_mask_one <= 7'h07;
		p2_ovr_one <= 7'h05;
		tick(2);
		p2_xfer(7'h3D, 1, 1'h1, 1'h0);
		p2_xfer(7'h38, 0, 1'h0, 1'h0);
		p2_mask_one <= 7'h00;
		$display("override test done");
		for (k = 0; k < 4; k = k + 1) begin
			p2_evt_mask <= 4'h1 << k;
			p2_evt <= 4'h1 << k;
			tick(1);
			p2_evt <= 4'h0;
			tick(4);
			check1(second_port_irq_out_oe_n, 1'h0);
			check1(first_port_irq_out_oe_n, 1'h1);
			p2_evt_clr <= 4'h1 << k;
			tick(1);
			p2_evt_clr <= 4'h0;
			tick(4);
			check1(second_port_irq_out_oe_n, 1'h1);
		end
		p2_evt_mask <= 4'h0;
		p1_evt_mask <= 4'h8;
		{p1_evt, p2_evt} <= 8'h8F;
		tick(1);
		{p1_evt, p2_evt} <= 8'h00;
		tick(4);
		check1(second_port_irq_out_oe_n, 1'h1);
		check1(first_port_irq_out_oe_n, 1'h0);
		check8({p1_pend, p2_pend}, 8'h8F);
		$display("interrupt test done");
		d = $urandom;
		exp_q.push_back({1'h1, d});
		c3_cmd(7'h26, 1'h0, d);
		check1(c3_nack, 1'h0);
		d = $urandom;
		p1_tx_data <= d;
		p1_tx_valid <= 1'h1;
		c3_cmd(7'h22, 1'h1, 8'h00);
		check8(c3_rd_data, d);
		c3_cmd(7'h30, 1'h0, 8'h00);
		check1(c3_nack, 1'h1);
		third_port_irq_in <= 1'h0;
		tick(5);
		check1(p3_irq_seen_q, 1'h1);
		check1(exp_q.size() == 0, 1'h1);
		$display("controller test done");
		arst_n <= 1'h0;
		boot_done <= 1'h0;
		p1_ctrl_mode <= 1'h1;
		tick(5);
		arst_n <= 1'h1;
		tick(2);
		check1(first_port_irq_out_oe_n, 1'h1);
		boot_done <= 1'h1;
		tick(3);
		c1_cmd_addr <= 7'h22;
		c1_cmd_valid <= 1'h1;
		tick(2);
		c1_cmd_valid <= 1'h0;
		check1(c1_busy, 1'h1);
		tick(4200);
		check1(c1_busy, 1'h0);
		check1(c1_nack, 1'h1);
		$display("controller mode test done");
		final_report;
	end
endmodule
